//--- bench/charge_overcurrent_timing_config_monitor.sv
`timescale 1ns/1ps
module charge_overcurrent_timing_config_monitor
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic [1:0] charge_threshold_sel,
   input wire logic charge_overcurrent_flag,
   input wire logic temp_sensor_supply_out,
   input wire logic charge_fet_enable,
   input wire logic fet_force_off,
   input wire logic short_circuit_detect,
   input wire logic short_circuit_trip,
   input wire logic discharge_oc_trip
);
   // ==========
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   int sc_cnt;
   int next_sc_cnt;
   always_comb next_sc_cnt = (short_circuit_detect && !short_circuit_trip) ? sc_cnt + 1 : 0;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) sc_cnt <= 0;
      else sc_cnt <= next_sc_cnt;
   cfg_echo_a: assert property (cfg_we |=> cfg_rdata == $past(cfg_wdata)
      && charge_threshold_sel == $past(cfg_wdata[6:5])) else $error("config readback wrong");
   supply_on_a: assert property ($rose(charge_overcurrent_flag) |->
      ##[0:1] temp_sensor_supply_out) else $error("sensor supply not on");
   auto_off_a: assert property ($rose(charge_overcurrent_flag) && !cfg_rdata[7] |->
      ##[0:1] (fet_force_off && !charge_fet_enable)) else $error("fets not off");
   keep_fets_a: assert property ($rose(fet_force_off) |-> !$past(cfg_rdata[7]))
      else $error("fets off while disabled");
   sc_min_a: assert property (short_circuit_trip |->
      sc_cnt >= (cfg_rdata[4] ? 1998000 : 17990)) else $error("short trip too early");
   sc_max_a: assert property (!cfg_rdata[4] && short_circuit_detect |-> sc_cnt <= 20010)
      else $error("short trip too late");
   sc_pulse_a: assert property (short_circuit_trip |=> !short_circuit_trip)
      else $error("short trip not a pulse");
   dis_pulse_a: assert property (discharge_oc_trip |=> !discharge_oc_trip)
      else $error("discharge trip not a pulse");
   cover property (short_circuit_trip);
   cover property (cfg_we);
   cover property ($rose(charge_overcurrent_flag));
endmodule
bind charge_overcurrent_timing_config charge_overcurrent_timing_config_monitor u_mon (.*);

//--- bench/charge_overcurrent_timing_config_tb.sv
`timescale 1ns/1ps
module charge_overcurrent_timing_config_tb;
   logic clk_sys = 1'h0, rst_n = 1'h0, charge_fet_set = 1'h0, charge_fet_wdata = 1'h0;
   logic flag_clear = 1'h0, charge_oc_detect = 1'h0, discharge_oc_detect = 1'h0;
   logic short_circuit_detect = 1'h0, we_d = 1'h0, cfg_we, charge_overcurrent_flag;
   logic temp_sensor_supply_out, charge_fet_enable, fet_force_off, discharge_oc_trip;
   logic short_circuit_trip;
   logic [1:0] discharge_timeout_sel = 2'h0, charge_threshold_sel;
   logic [7:0] cfg_wdata, cfg_rdata, d;
   logic [7:0] cq[$], sq[$];
   int err_count = 0, compares = 0, cyc = 0, t0 = 0;
   charge_overcurrent_timing_config u_charge_overcurrent_timing_config (.*);
   host_model u_host_model (.*);
   // ==========
   // reporting
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] v);
      cq.push_back(v);
      u_host_model.write(v);
   endtask
   task automatic hold(input int n);
      short_circuit_detect = 1'h1;
      t0 = cyc;
      repeat (n) @(posedge clk_sys);
      #1 short_circuit_detect = 1'h0;
   endtask
   // ==========
   // clock, monitor, timeout
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      we_d <= cfg_we;
      if (we_d)
      begin
         d = cq.pop_front();
         check(cfg_rdata, d);
         check(charge_threshold_sel, d[6:5]);
      end
      if (short_circuit_trip === 1'h1)
      begin
         d = sq.size() ? sq.pop_front() : 8'hFF;
         check({7'h00, (cyc - t0) inside {[17990:20010]}}, d);
      end
      if (cyc == 90000)
      begin
         err_count++;
         wrap_up;
      end
   end
   // ==========
   // stimulus
   initial
   begin
      void'($urandom(27));
      repeat (10) @(posedge clk_sys);
      #1 rst_n = 1'h1;
      for (int i = 0; i < 6; i++)
         wr(8'($urandom) & 8'hEF);
      discharge_timeout_sel = 2'($urandom);
      charge_fet_wdata = 1'h1;
      charge_fet_set = 1'h1;
      @(posedge clk_sys);
      #1 charge_fet_set = 1'h0;
      flag_clear = 1'h1;
      charge_oc_detect = 1'h1;
      discharge_oc_detect = 1'h1;
      @(posedge clk_sys);
      #1 flag_clear = 1'h0;
      check(charge_fet_enable, 1'h1);
      hold(15000);
      repeat (5) @(posedge clk_sys);
      #1 sq.push_back(8'h01);
      hold(20100);
      wr(8'h10);
      hold(22000);
      check(charge_overcurrent_flag, 1'h0);
      check(temp_sensor_supply_out, 1'h0);
      check(fet_force_off, 1'h0);
      check(discharge_oc_trip, 1'h0);
      check(8'(sq.size()), 8'h00);
      wrap_up;
   end
endmodule

//--- bench/host_model.sv
`timescale 1ns/1ps
module host_model
(
   input wire logic clk_sys,
   output logic cfg_we = 1'h0,
   output logic [7:0] cfg_wdata = 8'h00
);
   // ==========
   // register write, data inverted once released
   task automatic write(input logic [7:0] v);
      @(posedge clk_sys);
      #1 cfg_we = 1'h1;
      cfg_wdata = v;
      @(posedge clk_sys);
      #1 cfg_we = 1'h0;
      cfg_wdata = ~v;
   endtask
endmodule

//--- rtl/charge_oc_pkg.sv
package charge_oc_pkg;
   // ==========================================
   // register layout
   localparam logic [7:0] reg_reset = 8'h00;
   localparam int bit_auto_off_disable = 7;
   localparam int bit_thr_hi = 6;
   localparam int bit_thr_lo = 5;
   localparam int bit_sc_long = 4;
   localparam int bit_charge_prescale = 3;
   localparam int bit_discharge_prescale = 2;
   localparam int bit_tsel_hi = 1;
   localparam int bit_tsel_lo = 0;
   // ==========================================
   // timing
   localparam int clk_mhz = 200;
   localparam int tick_us = 10;
   localparam int tick_cycles = tick_us * clk_mhz;
   localparam int sc_short_us = 100;
   localparam int sc_long_us = 10000;
   localparam int charge_base_us = 80000;
   localparam int charge_fast_0_us = 2500;
   localparam int charge_fast_1_us = 4000;
   localparam int discharge_base_us = 160000;
   localparam int discharge_fast_0_us = 2500;
   localparam int discharge_fast_1_us = 5000;
   localparam int fast_2_us = 8000;
   localparam int fast_3_us = 16000;
   localparam int tw = 18;
   localparam logic [tw-1:0] sc_short_ticks = tw'(sc_short_us / tick_us);
   localparam logic [tw-1:0] sc_long_ticks = tw'(sc_long_us / tick_us);
   typedef enum logic [1:0] {det_idle, det_timing, det_tripped} det_state_t;

   function automatic logic [tw-1:0] charge_ticks(input logic fast, input logic [1:0] code);
      logic [tw-1:0] t;
      t = tw'((charge_base_us / tick_us) << code);
      if (fast)
      begin
         unique case (code)
            2'h0: t = tw'(charge_fast_0_us / tick_us);
            2'h1: t = tw'(charge_fast_1_us / tick_us);
            2'h2: t = tw'(fast_2_us / tick_us);
            2'h3: t = tw'(fast_3_us / tick_us);
         endcase
      end
      return t;
   endfunction

   function automatic logic [tw-1:0] discharge_ticks(input logic fast, input logic [1:0] code);
      logic [tw-1:0] t;
      t = tw'((discharge_base_us / tick_us) << code);
      if (fast)
      begin
         unique case (code)
            2'h0: t = tw'(discharge_fast_0_us / tick_us);
            2'h1: t = tw'(discharge_fast_1_us / tick_us);
            2'h2: t = tw'(fast_2_us / tick_us);
            2'h3: t = tw'(fast_3_us / tick_us);
         endcase
      end
      return t;
   endfunction
endpackage

//--- rtl/charge_overcurrent_timing_config.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] auto-off clear: charge overcurrent turns FETs off
// [RQ2] auto-off set: FETs left as they are
// [RQ3] charge overcurrent sets flag, enables sensor supply
// [RQ4] short-circuit long bit zero: 100us qualification
// [RQ5] short-circuit long bit one: 10ms qualification
// [RQ6] charge prescale shortens charge delay
// [RQ7] discharge prescale shortens discharge delay
// [RQ8] charge codes give 80/160/320/640ms
// [RQ9] prescaled charge codes give 2.5/4/8/16ms
// [RQ10] charge FET enable auto-cleared unless disabled
// [RQ11] discharge codes 160..1280ms, prescaled 2.5..16ms
// [RQ12] condition gone early restarts timer, no action
module charge_overcurrent_timing_config
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   input wire logic [1:0] discharge_timeout_sel,
   input wire logic charge_fet_set,
   input wire logic charge_fet_wdata,
   input wire logic flag_clear,
   input wire logic charge_oc_detect,
   input wire logic discharge_oc_detect,
   input wire logic short_circuit_detect,
   output logic charge_overcurrent_flag,
   output logic temp_sensor_supply_out,
   output logic charge_fet_enable,
   output logic fet_force_off,
   output logic discharge_oc_trip,
   output logic short_circuit_trip,
   output logic [1:0] charge_threshold_sel
);
   import charge_oc_pkg::*;
   // ==========================================
   // time base
   // one shared 10us tick paces every qualification timer
   logic [11:0] div_count;
   logic [11:0] next_div_count;
   logic tick;
   logic next_tick;

   always_comb
   begin
      next_tick = 1'b0;
      next_div_count = div_count + 12'h001;
      if (div_count == 12'(tick_cycles - 1))
      begin
         next_div_count = 12'h000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_count <= 12'h000;
         tick <= 1'b0;
      end
      else
      begin
         div_count <= next_div_count;
         tick <= next_tick;
      end
   end

   // ==========================================
   // configuration register
   // readback and threshold select mirror the register
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [tw-1:0] charge_limit;
   logic [tw-1:0] discharge_limit;
   logic [tw-1:0] sc_limit;

   always_comb
   begin
      next_cfg = cfg_we ? cfg_wdata : cfg;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg <= reg_reset;
         cfg_rdata <= reg_reset;
         charge_threshold_sel <= 2'h0;
      end
      else
      begin
         cfg <= next_cfg;
         cfg_rdata <= next_cfg;
         charge_threshold_sel <= {next_cfg[bit_thr_hi], next_cfg[bit_thr_lo]};
      end
   end

   // RQ6 RQ8 RQ9
   assign charge_limit = charge_ticks(cfg[bit_charge_prescale],
      {cfg[bit_tsel_hi], cfg[bit_tsel_lo]});
   // RQ7 RQ11
   assign discharge_limit = discharge_ticks(cfg[bit_discharge_prescale], discharge_timeout_sel);
   // RQ4 RQ5
   assign sc_limit = cfg[bit_sc_long] ? sc_long_ticks : sc_short_ticks;

   // ==========================================
   // qualification timers
   logic charge_trip;
   logic dis_trip;
   logic sc_trip;

   persist_timer u_charge
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(tick),
      .cond(charge_oc_detect),
      .limit(charge_limit),
      .trip(charge_trip)
   );

   persist_timer u_discharge
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(tick),
      .cond(discharge_oc_detect),
      .limit(discharge_limit),
      .trip(dis_trip)
   );

   persist_timer u_short
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(tick),
      .cond(short_circuit_detect),
      .limit(sc_limit),
      .trip(sc_trip)
   );

   // ==========================================
   // charge overcurrent flag and sensor supply
   logic next_flag;
   logic auto_off;

   always_comb
   begin
      auto_off = charge_trip && !cfg[bit_auto_off_disable]; // RQ1 RQ2
      next_flag = charge_overcurrent_flag;
      if (flag_clear)
         next_flag = 1'b0;
      // a trip in the same cycle as a clear wins
      if (charge_trip)
         next_flag = 1'b1; // RQ3
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         charge_overcurrent_flag <= 1'b0;
         temp_sensor_supply_out <= 1'b0;
      end
      else
      begin
         charge_overcurrent_flag <= next_flag; // RQ3
         temp_sensor_supply_out <= next_flag; // RQ3
      end
   end

   // ==========================================
   // charge fet enable and forced off level
   logic next_fet;
   logic next_force_off;

   always_comb
   begin
      next_fet = charge_fet_enable;
      if (charge_fet_set)
         next_fet = charge_fet_wdata;
      // automatic turn-off wins over a software write
      if (auto_off)
         next_fet = 1'b0; // RQ10
      next_force_off = fet_force_off;
      // only software turning the fet back on releases it
      if (charge_fet_set && charge_fet_wdata)
         next_force_off = 1'b0;
      if (auto_off)
         next_force_off = 1'b1; // RQ1 RQ2
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         charge_fet_enable <= 1'b0;
         fet_force_off <= 1'b0;
      end
      else
      begin
         charge_fet_enable <= next_fet;
         fet_force_off <= next_force_off;
      end
   end

   // ==========================================
   // qualified trip pulses
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         discharge_oc_trip <= 1'b0;
         short_circuit_trip <= 1'b0;
      end
      else
      begin
         discharge_oc_trip <= dis_trip; // RQ7 RQ11
         short_circuit_trip <= sc_trip; // RQ4 RQ5
      end
   end
endmodule

//--- rtl/persist_timer.sv
`timescale 1ns/1ps
module persist_timer
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cond,
   input wire logic [charge_oc_pkg::tw-1:0] limit,
   output logic trip
);
   import charge_oc_pkg::*;
   // ==========================================
   // qualification counter
   logic [tw-1:0] count;
   logic [tw-1:0] next_count;
   logic next_trip;

   always_comb
   begin
      next_count = count;
      next_trip = 1'b0;
      if (!cond)
         next_count = '0; // RQ12
      else if (tick)
      begin
         if (count + tw'(1) >= limit)
         begin
            next_trip = 1'b1;
            next_count = '0;
         end
         else
            next_count = count + tw'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= '0;
         trip <= 1'b0;
      end
      else
      begin
         count <= next_count;
         trip <= next_trip;
      end
   end
endmodule
